//--- hdl/sie_pkg.sv
// constants for the serial interrupt-enable block
package sie_pkg;
	// register bus
	localparam int unsigned ADDR_W = 4;
	localparam int unsigned DATA_W = 8;
	localparam logic [3:0] OFS_CTRL = 4'h0;
	localparam logic [3:0] OFS_EVT_STS = 4'h1;
	localparam logic [3:0] OFS_EVT_MASK = 4'h2;
	localparam logic [3:0] OFS_FLAG_VIEW = 4'h3;
	localparam logic [3:0] OFS_REQ_VIEW = 4'h4;
	// serial_irq_enable_ctrl fields
	localparam int unsigned BIT_TX_EMPTY_EN = 7;
	localparam int unsigned BIT_TX_END_EN = 6;
	localparam int unsigned BIT_RX_FULL_EN = 5;
	localparam int unsigned BIT_NO_ACK_EN = 4;
	localparam int unsigned BIT_STOP_EN = 3;
	localparam int unsigned BIT_ACK_JUDGE = 2;
	localparam int unsigned BIT_RX_ACK = 1;
	localparam int unsigned BIT_TX_ACK = 0;
	localparam logic [7:0] CTRL_RST = 8'h00;
	// flag view fields (serial_status_reg mirror)
	localparam int unsigned FLG_TX_EMPTY = 7;
	localparam int unsigned FLG_TX_END = 6;
	localparam int unsigned FLG_RX_FULL = 5;
	localparam int unsigned FLG_NO_ACK = 4;
	localparam int unsigned FLG_STOP = 3;
	localparam int unsigned FLG_ARB_LOST = 2;
	localparam int unsigned FLG_OVERRUN = 1;
	localparam int unsigned FLG_SYNC_FMT = 0;
	// request index, shared by event status, mask and request view
	localparam int unsigned NUM_REQ = 6;
	localparam int unsigned REQ_TX_EMPTY = 0;
	localparam int unsigned REQ_TX_END = 1;
	localparam int unsigned REQ_RX_FULL = 2;
	localparam int unsigned REQ_ERROR = 3;
	localparam int unsigned REQ_NO_ACK = 4;
	localparam int unsigned REQ_STOP = 5;
	localparam logic [5:0] EVT_STS_RST = 6'h00;
	localparam logic [5:0] EVT_MASK_RST = 6'h00;
	localparam logic [7:0] RDATA_IDLE = 8'h00;
endpackage

//--- hdl/sie_sts_if.sv
// carrier between the core and its sticky event status
`timescale 1ns/1ps
`default_nettype none
interface sie_sts_if;
	logic [sie_pkg::NUM_REQ-1:0] set;
	logic [sie_pkg::NUM_REQ-1:0] clr;
	logic [sie_pkg::NUM_REQ-1:0] sts;
	modport core (output set, output clr, input sts);
	modport stat (input set, input clr, output sts);
endinterface
`default_nettype wire

//--- hdl/sie_irq_gate.sv
// one gated interrupt request: enable and any of its source flags
`timescale 1ns/1ps
`default_nettype none
module sie_irq_gate #(
	parameter int unsigned N = 1
) (
	input wire logic i_clk, // clock
	input wire logic i_rst_n, // sync reset, low active
	input wire logic i_ce, // clock enable
	input wire logic i_en, // enable bit
	input wire logic [N-1:0] i_src, // source flags
	output logic o_req // level request
);
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_req <= 1'b0;
		end else if (i_ce) begin
			o_req <= i_en & (|i_src);
		end
	end
endmodule
`default_nettype wire

//--- hdl/sie_evt_status.sv
// sticky event status, write one to clear, set wins
`timescale 1ns/1ps
`default_nettype none
module sie_evt_status (
	input wire logic i_clk, // clock
	input wire logic i_rst_n, // sync reset, low active
	input wire logic i_ce, // clock enable
	sie_sts_if.stat sts_if // set, clear and state
);
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			sts_if.sts <= sie_pkg::EVT_STS_RST;
		end else if (i_ce) begin
			sts_if.sts <= (sts_if.sts & ~sts_if.clr) | sts_if.set;
		end
	end
endmodule
`default_nettype wire

//--- hdl/sie_irq_ctrl.sv
// interrupt-enable register and request gating of the two-wire serial unit
//
// Behaviour
// RULE1: transmit-empty request follows enable bit 7 and transmit-empty flag.
// RULE2: transmit-end request follows enable bit 6 and transmit-end flag.
// RULE3: transmit-end request drops once its flag or enable is cleared.
// RULE4: receive-full request follows bit 5; bit 5 also gates sync-format overrun.
// RULE5: receive-full request drops once its flag or enable is cleared.
// RULE6: bit 4 gates no-ack or arbitration-lost, and sync-format overrun.
// RULE7: no-ack request drops once no-ack, arbitration-lost and overrun are all cleared, or enable is cleared.
// RULE8: stop-detect request follows enable bit 3 and stop flag.
// RULE9: judgement select 0 ignores received acknowledge, transfer continues.
// RULE10: judgement select 1 with received acknowledge 1 halts continuous transfer.
// RULE11: transmit mode captures returned acknowledge in read-only bit 1.
// RULE12: receive mode drives bit 0 value during acknowledge bit time.
// RULE13: each request is a held level: flags AND enable.
`timescale 1ns/1ps
`default_nettype none
module sie_irq_ctrl (
	input wire logic i_clk, // 100 MHz clock
	input wire logic i_rst_n, // sync reset, low active
	input wire logic i_ce, // clock enable, freezes state
	input wire logic [3:0] i_addr, // register index
	input wire logic [7:0] i_wdata, // write data
	input wire logic i_wr, // write strobe
	input wire logic i_rd, // read strobe
	output logic [7:0] o_rdata, // read data, cycle after strobe
	input wire logic i_tx_empty_flag, // transmit data empty
	input wire logic i_tx_end_flag, // transmit end
	input wire logic i_rx_full_flag, // receive data full
	input wire logic i_no_ack_flag, // no acknowledge seen
	input wire logic i_arb_lost_flag, // arbitration lost
	input wire logic i_overrun_flag, // overrun
	input wire logic i_stop_flag, // stop condition detected
	input wire logic i_sync_fmt, // clocked synchronous format
	input wire logic i_tx_mode, // transmit mode
	input wire logic i_ack_sample_vld, // acknowledge bit sampled
	input wire logic i_ack_sample, // sampled acknowledge value
	input wire logic i_ack_time, // acknowledge bit time
	output logic o_tx_empty_irq, // transmit-empty request
	output logic o_tx_end_irq, // transmit-end request
	output logic o_rx_full_irq, // receive-full request
	output logic o_error_irq, // overrun error request
	output logic o_no_ack_irq, // no-acknowledge request
	output logic o_stop_detect_irq, // stop-detect request
	output logic o_ack_out, // acknowledge bit to send
	output logic o_ack_oe, // acknowledge drive enable
	output logic o_xfer_halt, // halt continuous transfer
	output logic o_irq // combined interrupt
);
	// ==========================================================
	// register decode
	logic wr_ctrl;
	logic wr_sts;
	logic wr_mask;
	assign wr_ctrl = i_wr && (i_addr == sie_pkg::OFS_CTRL);
	assign wr_sts = i_wr && (i_addr == sie_pkg::OFS_EVT_STS);
	assign wr_mask = i_wr && (i_addr == sie_pkg::OFS_EVT_MASK);

	// ==========================================================
	// serial_irq_enable_ctrl
	logic tx_empty_irq_en_r;
	logic tx_end_irq_en_r;
	logic rx_full_irq_en_r;
	logic no_ack_irq_en_r;
	logic stop_detect_irq_en_r;
	logic ack_judge_sel_r;
	logic rx_ack_value_r;
	logic tx_ack_value_r;

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			tx_empty_irq_en_r <= sie_pkg::CTRL_RST[sie_pkg::BIT_TX_EMPTY_EN];
			tx_end_irq_en_r <= sie_pkg::CTRL_RST[sie_pkg::BIT_TX_END_EN];
			rx_full_irq_en_r <= sie_pkg::CTRL_RST[sie_pkg::BIT_RX_FULL_EN];
			no_ack_irq_en_r <= sie_pkg::CTRL_RST[sie_pkg::BIT_NO_ACK_EN];
			stop_detect_irq_en_r <= sie_pkg::CTRL_RST[sie_pkg::BIT_STOP_EN];
			ack_judge_sel_r <= sie_pkg::CTRL_RST[sie_pkg::BIT_ACK_JUDGE];
			tx_ack_value_r <= sie_pkg::CTRL_RST[sie_pkg::BIT_TX_ACK];
		end else if (i_ce && wr_ctrl) begin
			tx_empty_irq_en_r <= i_wdata[sie_pkg::BIT_TX_EMPTY_EN];
			tx_end_irq_en_r <= i_wdata[sie_pkg::BIT_TX_END_EN];
			rx_full_irq_en_r <= i_wdata[sie_pkg::BIT_RX_FULL_EN];
			no_ack_irq_en_r <= i_wdata[sie_pkg::BIT_NO_ACK_EN];
			stop_detect_irq_en_r <= i_wdata[sie_pkg::BIT_STOP_EN];
			ack_judge_sel_r <= i_wdata[sie_pkg::BIT_ACK_JUDGE];
			tx_ack_value_r <= i_wdata[sie_pkg::BIT_TX_ACK];
		end
	end

	// received acknowledge, hardware only
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			rx_ack_value_r <= sie_pkg::CTRL_RST[sie_pkg::BIT_RX_ACK];
		end else if (i_ce && i_ack_sample_vld && i_tx_mode) begin
			rx_ack_value_r <= i_ack_sample; // RULE11
		end
	end

	// ==========================================================
	// request gating
	logic [sie_pkg::NUM_REQ-1:0] req;
	logic ovr_sync;
	assign ovr_sync = i_overrun_flag & i_sync_fmt;

	sie_irq_gate #(.N(1)) u_gate_tx_empty ( // RULE1 RULE13
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_ce(i_ce),
		.i_en(tx_empty_irq_en_r),
		.i_src(i_tx_empty_flag),
		.o_req(req[sie_pkg::REQ_TX_EMPTY])
	);

	sie_irq_gate #(.N(1)) u_gate_tx_end ( // RULE2 RULE3 RULE13
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_ce(i_ce),
		.i_en(tx_end_irq_en_r),
		.i_src(i_tx_end_flag),
		.o_req(req[sie_pkg::REQ_TX_END])
	);

	sie_irq_gate #(.N(1)) u_gate_rx_full ( // RULE4 RULE5 RULE13
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_ce(i_ce),
		.i_en(rx_full_irq_en_r),
		.i_src(i_rx_full_flag),
		.o_req(req[sie_pkg::REQ_RX_FULL])
	);

	// overrun error in sync format, enabled by either receive or no-ack enable
	sie_irq_gate #(.N(1)) u_gate_error ( // RULE4 RULE6 RULE13
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_ce(i_ce),
		.i_en(rx_full_irq_en_r | no_ack_irq_en_r),
		.i_src(ovr_sync),
		.o_req(req[sie_pkg::REQ_ERROR])
	);

	sie_irq_gate #(.N(3)) u_gate_no_ack ( // RULE6 RULE7 RULE13
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_ce(i_ce),
		.i_en(no_ack_irq_en_r),
		.i_src({i_no_ack_flag, i_arb_lost_flag, ovr_sync}),
		.o_req(req[sie_pkg::REQ_NO_ACK])
	);

	sie_irq_gate #(.N(1)) u_gate_stop ( // RULE8 RULE13
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_ce(i_ce),
		.i_en(stop_detect_irq_en_r),
		.i_src(i_stop_flag),
		.o_req(req[sie_pkg::REQ_STOP])
	);

	assign o_tx_empty_irq = req[sie_pkg::REQ_TX_EMPTY];
	assign o_tx_end_irq = req[sie_pkg::REQ_TX_END];
	assign o_rx_full_irq = req[sie_pkg::REQ_RX_FULL];
	assign o_error_irq = req[sie_pkg::REQ_ERROR];
	assign o_no_ack_irq = req[sie_pkg::REQ_NO_ACK];
	assign o_stop_detect_irq = req[sie_pkg::REQ_STOP];

	// ==========================================================
	// event status: rising edge of each request is sticky
	logic [sie_pkg::NUM_REQ-1:0] req_d_r;
	logic [sie_pkg::NUM_REQ-1:0] evt_mask_r;
	sie_sts_if sts_if ();

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			req_d_r <= sie_pkg::EVT_STS_RST;
		end else if (i_ce) begin
			req_d_r <= req;
		end
	end

	assign sts_if.set = req & ~req_d_r;
	assign sts_if.clr = wr_sts ? i_wdata[sie_pkg::NUM_REQ-1:0] : sie_pkg::EVT_STS_RST;

	sie_evt_status u_evt_status (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_ce(i_ce),
		.sts_if(sts_if)
	);

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			evt_mask_r <= sie_pkg::EVT_MASK_RST;
		end else if (i_ce && wr_mask) begin
			evt_mask_r <= i_wdata[sie_pkg::NUM_REQ-1:0];
		end
	end

	// level interrupt, one cycle behind the status
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_irq <= 1'b0;
		end else if (i_ce) begin
			o_irq <= |(sts_if.sts & evt_mask_r);
		end
	end

	// ==========================================================
	// acknowledge handling
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_xfer_halt <= 1'b0;
		end else if (i_ce) begin
			// select 0 never halts whatever the received bit
			o_xfer_halt <= ack_judge_sel_r & rx_ack_value_r; // RULE9 RULE10
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_ack_out <= 1'b0;
			o_ack_oe <= 1'b0;
		end else if (i_ce) begin
			o_ack_oe <= i_ack_time & ~i_tx_mode; // RULE12
			o_ack_out <= tx_ack_value_r; // RULE12
		end
	end

	// ==========================================================
	// read path
	logic [7:0] ctrl_view;
	logic [7:0] flag_view;
	logic [7:0] rd_mux;

	always_comb begin
		ctrl_view = sie_pkg::CTRL_RST;
		ctrl_view[sie_pkg::BIT_TX_EMPTY_EN] = tx_empty_irq_en_r;
		ctrl_view[sie_pkg::BIT_TX_END_EN] = tx_end_irq_en_r;
		ctrl_view[sie_pkg::BIT_RX_FULL_EN] = rx_full_irq_en_r;
		ctrl_view[sie_pkg::BIT_NO_ACK_EN] = no_ack_irq_en_r;
		ctrl_view[sie_pkg::BIT_STOP_EN] = stop_detect_irq_en_r;
		ctrl_view[sie_pkg::BIT_ACK_JUDGE] = ack_judge_sel_r;
		ctrl_view[sie_pkg::BIT_RX_ACK] = rx_ack_value_r;
		ctrl_view[sie_pkg::BIT_TX_ACK] = tx_ack_value_r;
	end

	always_comb begin
		flag_view = sie_pkg::RDATA_IDLE;
		flag_view[sie_pkg::FLG_TX_EMPTY] = i_tx_empty_flag;
		flag_view[sie_pkg::FLG_TX_END] = i_tx_end_flag;
		flag_view[sie_pkg::FLG_RX_FULL] = i_rx_full_flag;
		flag_view[sie_pkg::FLG_NO_ACK] = i_no_ack_flag;
		flag_view[sie_pkg::FLG_STOP] = i_stop_flag;
		flag_view[sie_pkg::FLG_ARB_LOST] = i_arb_lost_flag;
		flag_view[sie_pkg::FLG_OVERRUN] = i_overrun_flag;
		flag_view[sie_pkg::FLG_SYNC_FMT] = i_sync_fmt;
	end

	always_comb begin
		case (i_addr)
			sie_pkg::OFS_CTRL: begin
				rd_mux = ctrl_view;
			end
			sie_pkg::OFS_EVT_STS: begin
				rd_mux = {2'b00, sts_if.sts};
			end
			sie_pkg::OFS_EVT_MASK: begin
				rd_mux = {2'b00, evt_mask_r};
			end
			sie_pkg::OFS_FLAG_VIEW: begin
				rd_mux = flag_view;
			end
			sie_pkg::OFS_REQ_VIEW: begin
				rd_mux = {2'b00, req};
			end
			default: begin
				rd_mux = sie_pkg::RDATA_IDLE;
			end
		endcase
	end

	// data valid only in the cycle after the strobe
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_rdata <= sie_pkg::RDATA_IDLE;
		end else if (i_ce) begin
			o_rdata <= i_rd ? rd_mux : sie_pkg::RDATA_IDLE;
		end
	end
endmodule
`default_nettype wire

//--- tb/sie_irq_ctrl_assertions.sv
// checker for the serial interrupt-enable block ports
`timescale 1ns/1ps
`default_nettype none
module sie_irq_ctrl_assertions (
	input wire logic i_clk, // clock
	input wire logic i_rst_n, // sync reset, low active
	input wire logic i_rd, // read strobe
	input wire logic [7:0] o_rdata, // read data
	input wire logic i_tx_empty_flag, // transmit empty
	input wire logic i_tx_end_flag, // transmit end
	input wire logic i_rx_full_flag, // receive full
	input wire logic i_no_ack_flag, // no acknowledge
	input wire logic i_arb_lost_flag, // arbitration lost
	input wire logic i_overrun_flag, // overrun
	input wire logic i_stop_flag, // stop seen
	input wire logic i_sync_fmt, // sync format
	input wire logic i_tx_mode, // transmit mode
	input wire logic i_ack_sample_vld, // ack sampled
	input wire logic i_ack_sample, // ack value
	input wire logic i_ack_time, // ack bit time
	input wire logic o_tx_empty_irq, // request
	input wire logic o_tx_end_irq, // request
	input wire logic o_rx_full_irq, // request
	input wire logic o_error_irq, // request
	input wire logic o_no_ack_irq, // request
	input wire logic o_stop_detect_irq, // request
	input wire logic o_ack_oe, // ack drive enable
	input wire logic o_xfer_halt // halt
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	// ==========================================
	// sequences
	sequence s_ack_zero;
		i_ack_sample_vld && i_tx_mode && !i_ack_sample;
	endsequence
	// ==========================================
	// properties
	chk_tx_empty_src: assert property (o_tx_empty_irq |-> $past(i_tx_empty_flag))
		else $error("transmit-empty request without flag");
	chk_tx_end_drop: assert property (!i_tx_end_flag |=> !o_tx_end_irq)
		else $error("transmit-end request held after flag cleared");
	chk_rx_full_drop: assert property (!i_rx_full_flag |=> !o_rx_full_irq)
		else $error("receive-full request held after flag cleared");
	chk_no_ack_src: assert property (o_no_ack_irq |->
		$past(i_no_ack_flag || i_arb_lost_flag || (i_overrun_flag && i_sync_fmt)))
		else $error("no-ack request without source");
	chk_error_src: assert property (o_error_irq |-> $past(i_overrun_flag && i_sync_fmt))
		else $error("error request without sync overrun");
	chk_stop_src: assert property (o_stop_detect_irq |-> $past(i_stop_flag))
		else $error("stop request without flag");
	chk_ack_drive: assert property ($past(i_rst_n) |-> o_ack_oe == $past(i_ack_time && !i_tx_mode))
		else $error("ack drive enable wrong");
	chk_halt_clear: assert property (s_ack_zero |=> ##1 !o_xfer_halt)
		else $error("halt held after zero ack");
	chk_rdata_idle: assert property ($past(i_rst_n) && !$past(i_rd) |-> o_rdata == 8'h00)
		else $error("read data outside read cycle");
endmodule
bind sie_irq_ctrl sie_irq_ctrl_assertions sie_irq_ctrl_assertions_i (.i_clk(i_clk),
	.i_rst_n(i_rst_n), .i_rd(i_rd), .o_rdata(o_rdata), .i_tx_empty_flag(i_tx_empty_flag),
	.i_tx_end_flag(i_tx_end_flag), .i_rx_full_flag(i_rx_full_flag),
	.i_no_ack_flag(i_no_ack_flag), .i_arb_lost_flag(i_arb_lost_flag),
	.i_overrun_flag(i_overrun_flag), .i_stop_flag(i_stop_flag), .i_sync_fmt(i_sync_fmt),
	.i_tx_mode(i_tx_mode), .i_ack_sample_vld(i_ack_sample_vld), .i_ack_sample(i_ack_sample),
	.i_ack_time(i_ack_time), .o_tx_empty_irq(o_tx_empty_irq), .o_tx_end_irq(o_tx_end_irq),
	.o_rx_full_irq(o_rx_full_irq), .o_error_irq(o_error_irq), .o_no_ack_irq(o_no_ack_irq),
	.o_stop_detect_irq(o_stop_detect_irq), .o_ack_oe(o_ack_oe), .o_xfer_halt(o_xfer_halt));
`default_nettype wire

//--- tb/sie_flag_model.sv
// status flag source: engine sets flags, software clears them
`timescale 1ns/1ps
`default_nettype none
module sie_flag_model (
	input wire logic i_clk, // clock
	input wire logic i_rst_n, // sync reset, low active
	input wire logic [6:0] i_set, // engine set pulses
	input wire logic [6:0] i_clr, // software clear pulses
	output logic [6:0] o_flags // flag levels
);
	// bits: tx_empty, tx_end, rx_full, no_ack, arb_lost, overrun, stop
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_flags <= 7'h00;
		end else begin
			o_flags <= (o_flags & ~i_clr) | i_set;
		end
	end
endmodule
`default_nettype wire

//--- tb/sie_irq_ctrl_tb.sv
// self-checking bench for the serial interrupt-enable block
`timescale 1ns/1ps
`default_nettype none
module sie_irq_ctrl_tb;
	logic i_clk = 1'b0, i_rst_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
	logic [3:0] i_addr = 4'h0;
	logic [7:0] i_wdata = 8'h00, o_rdata;
	logic [6:0] set = 7'h00, clr = 7'h00, flg;
	logic sync = 1'b0, txm = 1'b0, vld = 1'b0, smp = 1'b0, atm = 1'b0;
	logic ce = 1'b1;
	logic o_tx_empty_irq, o_tx_end_irq, o_rx_full_irq, o_error_irq, o_no_ack_irq;
	logic o_stop_detect_irq, o_ack_out, o_ack_oe, o_xfer_halt, o_irq;
	logic [7:0] q;
	int err_total = 0, compares = 0;
	assign q = {2'b00, o_stop_detect_irq, o_no_ack_irq, o_error_irq, o_rx_full_irq, o_tx_end_irq,
		o_tx_empty_irq};
	always #5 i_clk = ~i_clk;
	sie_flag_model sie_flag_model_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_set(set),
		.i_clr(clr), .o_flags(flg));
	sie_irq_ctrl sie_irq_ctrl_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(ce),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.i_tx_empty_flag(flg[0]), .i_tx_end_flag(flg[1]), .i_rx_full_flag(flg[2]),
		.i_no_ack_flag(flg[3]), .i_arb_lost_flag(flg[4]), .i_overrun_flag(flg[5]),
		.i_stop_flag(flg[6]), .i_sync_fmt(sync), .i_tx_mode(txm), .i_ack_sample_vld(vld),
		.i_ack_sample(smp), .i_ack_time(atm), .o_tx_empty_irq(o_tx_empty_irq),
		.o_tx_end_irq(o_tx_end_irq), .o_rx_full_irq(o_rx_full_irq), .o_error_irq(o_error_irq),
		.o_no_ack_irq(o_no_ack_irq), .o_stop_detect_irq(o_stop_detect_irq),
		.o_ack_out(o_ack_out), .o_ack_oe(o_ack_oe), .o_xfer_halt(o_xfer_halt), .o_irq(o_irq));
	// ==========================================
	// tasks
	task automatic give_verdict;
		$display("compares %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge i_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] exp);
		@(posedge i_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1 cmp(o_rdata, exp);
	endtask
	task automatic flags(input logic [6:0] s, input logic [6:0] c);
		@(posedge i_clk);
		set <= s;
		clr <= c;
		@(posedge i_clk);
		set <= 7'h00;
		clr <= 7'h00;
		step(2);
	endtask
	task automatic ack(input logic v);
		@(posedge i_clk);
		vld <= 1'b1;
		smp <= v;
		@(posedge i_clk);
		vld <= 1'b0;
		step(2);
	endtask
	// ==========================================
	// sequence
	initial begin
		#100000 err_total++;
		give_verdict();
	end
	initial begin
		repeat (3) @(posedge i_clk);
		i_rst_n <= 1'b1;
		rd(4'h0, 8'h00);
		rd(4'h1, 8'h00);
		rd(4'h2, 8'h00);
		rd(4'hF, 8'h00);
		$display("test reset done");
		flags(7'h5F, 7'h00);
		cmp(q, 8'h00);
		wr(4'h0, 8'hF8);
		step(2);
		cmp(q, 8'h37);
		rd(4'h4, 8'h37);
		rd(4'h3, 8'hFC);
		flags(7'h00, 7'h07);
		cmp(q, 8'h30);
		flags(7'h00, 7'h08);
		cmp(q, 8'h30);
		flags(7'h00, 7'h50);
		cmp(q, 8'h00);
		flags(7'h02, 7'h00);
		cmp(q, 8'h02);
		wr(4'h0, 8'hB8);
		step(2);
		cmp(q, 8'h00);
		@(posedge i_clk);
		sync <= 1'b1;
		flags(7'h20, 7'h02);
		wr(4'h0, 8'h20);
		step(2);
		cmp(q, 8'h08);
		wr(4'h0, 8'h10);
		step(2);
		cmp(q, 8'h18);
		flags(7'h00, 7'h20);
		cmp(q, 8'h00);
		$display("test gating done");
		rd(4'h1, 8'h3F);
		cmp(o_irq, 8'h00);
		wr(4'h2, 8'h3F);
		rd(4'h2, 8'h3F);
		step(2);
		cmp(o_irq, 8'h01);
		wr(4'h1, 8'h3F);
		rd(4'h1, 8'h00);
		step(2);
		cmp(o_irq, 8'h00);
		$display("test interrupt done");
		wr(4'h0, 8'h07);
		rd(4'h0, 8'h05);
		@(posedge i_clk);
		txm <= 1'b1;
		ack(1'b1);
		rd(4'h0, 8'h07);
		cmp(o_xfer_halt, 8'h01);
		wr(4'h0, 8'h01);
		step(2);
		cmp(o_xfer_halt, 8'h00);
		wr(4'h0, 8'h05);
		step(2);
		cmp(o_xfer_halt, 8'h01);
		ack(1'b0);
		cmp(o_xfer_halt, 8'h00);
		@(posedge i_clk);
		txm <= 1'b0;
		atm <= 1'b1;
		ack(1'b1);
		rd(4'h0, 8'h05);
		cmp({o_ack_oe, o_ack_out}, 8'h03);
		wr(4'h0, 8'h04);
		step(2);
		cmp({o_ack_oe, o_ack_out}, 8'h02);
		$display("test acknowledge done");
		// clock enable low: write must not land
		@(posedge i_clk);
		ce <= 1'b0;
		wr(4'h0, 8'h00);
		@(posedge i_clk);
		ce <= 1'b1;
		rd(4'h0, 8'h04);
		$display("test clock enable done");
		give_verdict();
	end
endmodule
`default_nettype wire
